// ### verilog/vs_defines.svh
// register offsets, field positions, codes and reset values
`ifndef VS_DEFINES_SVH
`define VS_DEFINES_SVH
`define A_CTRL      8'h00
`define A_LPORT     8'h04
`define A_PCID      8'h08
`define A_PPORT     8'h0C
`define A_DLEN      8'h10
`define A_BALLOC    8'h14
`define A_CONSUME   8'h18
`define A_STATUS    8'h1C
`define A_PFREE     8'h20
`define A_GCID      8'h24
`define A_TOUT      8'h28
`define CTRL_CONN   0
`define CTRL_CLOSE  1
`define CTRL_SEND   2
`define CTRL_LISTEN 3
`define SHUT_NO_RX  0
`define SHUT_NO_TX  1
`define SHUT_BOTH   32'h0000_0003
`define TYPE_STREAM 16'h0001
`define OP_INVALID  16'h0000
`define OP_REQUEST  16'h0001
`define OP_RESPONSE 16'h0002
`define OP_RST      16'h0003
`define OP_SHUTDOWN 16'h0004
`define OP_RW       16'h0005
`define OP_CRED_UPD 16'h0006
`define OP_CRED_REQ 16'h0007
`define EV_TRANSPORT_RESET 32'h0000_0000
`define RST_BALLOC  32'h0000_1000
`define RST_TOUT    32'h0000_0400
`endif

// ### verilog/vs_pkg.sv
// types of the stream socket driver engine
package vs_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_CONN, ST_EST, ST_CLOSE} conn_t;
	typedef struct packed {
		conn_t       st;
		logic [31:0] lcid;
		logic        listen;
		logic [31:0] lport;
		logic [31:0] pcid;
		logic [31:0] pport;
		logic [31:0] dlen;
		logic [31:0] balloc;
		logic [31:0] tout;
		logic [31:0] txc;
		logic [31:0] fwd;
		logic [31:0] palloc;
		logic [31:0] pfwd;
		logic [31:0] rxb;
		logic [1:0]  pshut;
		logic        p_conn;
		logic        p_close;
		logic        p_send;
		logic        p_cred;
		logic        p_rst;
		logic        rep_v;
		logic [15:0] rep_op;
		logic [63:0] rep_cid;
		logic [31:0] rep_sport;
		logic [31:0] rep_dport;
		logic [31:0] tmr;
		logic        tv;
		logic [63:0] t_dcid;
		logic [31:0] t_sport;
		logic [31:0] t_dport;
		logic [31:0] t_len;
		logic [15:0] t_op;
		logic [31:0] t_flags;
		logic [31:0] t_balloc;
		logic [31:0] t_fwd;
		logic [31:0] prdata;
		logic        pslverr;
	} ctl_t;
endpackage : vs_pkg

// ### verilog/vs_driver.sv
// stream socket driver engine: apb control, tx/rx/event queue ports
//
// Contract
// - driver keeps draining rx while tx is full, using a spare slot.
// - a flow is the source and destination cid and port tuple.
// - only stream type, encoded as type value 1.
// - credit counts payload bytes only, never header bytes.
// - each side advertises buf_alloc and a free-running fwd_cnt.
// - peer free = peer buf_alloc minus (tx count minus peer fwd_cnt).
// - data is sent only when peer free space covers the payload.
// - short of credit, hold data and recheck with latest credit values.
// - a credit request is answered with a credit update.
// - unsolicited credit updates may be sent and are always accepted.
// - every flow packet carries current buf_alloc and fwd_cnt.
// - driver uses guest_cid as source cid of every outgoing packet; sends guest_cid[31:0] from the last transport reset, 0 until the first.
// - a packet with unknown type is answered with a reset.
// - request gets response if listening, else reset; here a request is also reset unless the state is ST_IDLE.
// - shutdown bit 0 no more receive, bit 1 no more send, latched.
// - a reset aborts a connect attempt or tears down a connection.
// - close sends shutdown both ways, waits for reset, else resets itself.
// - on transport reset, reread guest_cid, drop connections, keep listener.
// - tx buffers are only read by device, rx only written.
// - op codes 0 invalid through 7 credit request.
// - packets start with the fixed little-endian header layout.
`timescale 1ns/100ps
`include "vs_defines.svh"

module vs_driver
	import vs_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [63:0] guest_cid,
	output logic             tx_valid,
	input  wire logic        tx_ready,
	output logic      [63:0] tx_src_cid,
	output logic      [63:0] tx_dst_cid,
	output logic      [31:0] tx_src_port,
	output logic      [31:0] tx_dst_port,
	output logic      [31:0] tx_len,
	output logic      [15:0] tx_type,
	output logic      [15:0] tx_op,
	output logic      [31:0] tx_flags,
	output logic      [31:0] tx_buf_alloc,
	output logic      [31:0] tx_fwd_cnt,
	input  wire logic        rx_valid,
	output logic             rx_ready,
	input  wire logic [63:0] rx_src_cid,
	input  wire logic [63:0] rx_dst_cid,
	input  wire logic [31:0] rx_src_port,
	input  wire logic [31:0] rx_dst_port,
	input  wire logic [31:0] rx_len,
	input  wire logic [15:0] rx_type,
	input  wire logic [15:0] rx_op,
	input  wire logic [31:0] rx_flags,
	input  wire logic [31:0] rx_buf_alloc,
	input  wire logic [31:0] rx_fwd_cnt,
	input  wire logic        ev_valid,
	output logic             ev_ready,
	input  wire logic [31:0] ev_id
);

	ctl_t s_r;
	ctl_t s_nxt;

	// peer free space in modular 32-bit arithmetic
	function automatic logic [31:0] peer_free(
		input logic [31:0] palloc,
		input logic [31:0] txc,
		input logic [31:0] pfwd
	);
		peer_free = palloc - (txc - pfwd);
	endfunction : peer_free

	logic        wr;
	logic        rd;
	logic        rx_take;
	logic        ev_take;
	logic        flow_hit;
	logic [31:0] pfree;

	assign wr       = psel & penable & pwrite;
	assign rd       = psel & ~penable;
	assign rx_take  = rx_valid & rx_ready;
	assign ev_take  = ev_valid & ev_ready;
	assign pfree    = peer_free(s_r.palloc, s_r.txc, s_r.pfwd);
	assign flow_hit = (s_r.st != ST_IDLE)
		&& (rx_src_cid == {32'h0000_0000, s_r.pcid})
		&& (rx_src_port == s_r.pport)
		&& (rx_dst_cid == {32'h0000_0000, s_r.lcid})
		&& (rx_dst_port == s_r.lport);

	// one reply slot outside the tx queue lets rx drain while tx stalls
	assign rx_ready = ~s_r.rep_v;
	assign ev_ready = 1'b1;
	assign pready   = 1'b1;
	assign prdata   = s_r.prdata;
	assign pslverr  = s_r.pslverr;

	// tx is an outgoing header that the device only reads
	assign tx_valid     = s_r.tv;
	assign tx_src_cid   = {32'h0000_0000, s_r.lcid};
	assign tx_dst_cid   = s_r.t_dcid;
	assign tx_src_port  = s_r.t_sport;
	assign tx_dst_port  = s_r.t_dport;
	assign tx_len       = s_r.t_len;
	assign tx_type      = `TYPE_STREAM;
	assign tx_op        = s_r.t_op;
	assign tx_flags     = s_r.t_flags;
	assign tx_buf_alloc = s_r.t_balloc;
	assign tx_fwd_cnt   = s_r.t_fwd;

	always_comb
	begin
		s_nxt = s_r;

		// tx side: drain the output slot, then load the next packet
		if (s_r.tv && tx_ready)
		begin
			s_nxt.tv = 1'b0;
		end
		if (!s_r.tv)
		begin
			s_nxt.t_balloc = s_r.balloc;
			s_nxt.t_fwd    = s_r.fwd;
			s_nxt.t_len    = 32'h0000_0000;
			s_nxt.t_flags  = 32'h0000_0000;
			s_nxt.t_dcid   = {32'h0000_0000, s_r.pcid};
			s_nxt.t_sport  = s_r.lport;
			s_nxt.t_dport  = s_r.pport;
			if (s_r.rep_v)
			begin
				s_nxt.tv      = 1'b1;
				s_nxt.rep_v   = 1'b0;
				s_nxt.t_op    = s_r.rep_op;
				s_nxt.t_dcid  = s_r.rep_cid;
				s_nxt.t_sport = s_r.rep_sport;
				s_nxt.t_dport = s_r.rep_dport;
			end
			else if (s_r.p_rst)
			begin
				s_nxt.tv    = 1'b1;
				s_nxt.p_rst = 1'b0;
				s_nxt.t_op  = `OP_RST;
			end
			else if (s_r.p_conn)
			begin
				s_nxt.tv     = 1'b1;
				s_nxt.p_conn = 1'b0;
				s_nxt.t_op   = `OP_REQUEST;
				s_nxt.st     = ST_CONN;
			end
			else if (s_r.p_close)
			begin
				s_nxt.tv      = 1'b1;
				s_nxt.p_close = 1'b0;
				s_nxt.t_op    = `OP_SHUTDOWN;
				s_nxt.t_flags = `SHUT_BOTH;
				s_nxt.st      = ST_CLOSE;
				s_nxt.tmr     = s_r.tout;
			end
			else if (s_r.p_cred)
			begin
				s_nxt.tv     = 1'b1;
				s_nxt.p_cred = 1'b0;
				s_nxt.t_op   = `OP_CRED_UPD;
			end
			else if (s_r.p_send)
			begin
				if (s_r.pshut[`SHUT_NO_RX])
				begin
					s_nxt.p_send = 1'b0;
				end
				else if (pfree >= s_r.dlen)
				begin
					s_nxt.tv     = 1'b1;
					s_nxt.p_send = 1'b0;
					s_nxt.t_op   = `OP_RW;
					s_nxt.t_len  = s_r.dlen;
					s_nxt.txc    = s_r.txc + s_r.dlen;
				end
			end
		end

		// close wait: no reset from the peer in time, reset it ourselves
		if (s_r.st == ST_CLOSE)
		begin
			if (s_r.tmr == 32'h0000_0000)
			begin
				s_nxt.st    = ST_IDLE;
				s_nxt.p_rst = 1'b1;
			end
			else
			begin
				s_nxt.tmr = s_r.tmr - 32'h0000_0001;
			end
		end

		// rx side: incoming headers that the device wrote
		if (rx_take)
		begin
			s_nxt.rep_cid   = rx_src_cid;
			s_nxt.rep_sport = rx_dst_port;
			s_nxt.rep_dport = rx_src_port;
			s_nxt.rep_op    = `OP_RST;
			if (rx_type != `TYPE_STREAM)
			begin
				s_nxt.rep_v = 1'b1;
			end
			else if (flow_hit)
			begin
				s_nxt.palloc = rx_buf_alloc;
				s_nxt.pfwd   = rx_fwd_cnt;
				case (rx_op)
					`OP_RESPONSE:
					begin
						if (s_r.st == ST_CONN)
						begin
							s_nxt.st = ST_EST;
						end
					end
					`OP_RST:
					begin
						s_nxt.st      = ST_IDLE;
						s_nxt.p_send  = 1'b0;
						s_nxt.p_close = 1'b0;
						s_nxt.p_cred  = 1'b0;
					end
					`OP_SHUTDOWN:
					begin
						s_nxt.pshut = s_r.pshut | rx_flags[1:0];
					end
					`OP_RW:
					begin
						s_nxt.rxb = s_r.rxb + rx_len;
					end
					`OP_CRED_UPD:
					begin
						s_nxt.palloc = rx_buf_alloc;
					end
					`OP_CRED_REQ:
					begin
						s_nxt.rep_v  = 1'b1;
						s_nxt.rep_op = `OP_CRED_UPD;
					end
					`OP_REQUEST:
					begin
						s_nxt.rep_v = 1'b1;
					end
					default:
					begin
						s_nxt.rep_v = 1'b1;
					end
				endcase
			end
			else if (rx_op == `OP_REQUEST)
			begin
				s_nxt.rep_v = 1'b1;
				if (s_r.listen && s_r.st == ST_IDLE
					&& rx_dst_port == s_r.lport
					&& rx_dst_cid == {32'h0000_0000, s_r.lcid})
				begin
					s_nxt.rep_op = `OP_RESPONSE;
					s_nxt.st     = ST_EST;
					s_nxt.pcid   = rx_src_cid[31:0];
					s_nxt.pport  = rx_src_port;
					s_nxt.palloc = rx_buf_alloc;
					s_nxt.pfwd   = rx_fwd_cnt;
					s_nxt.txc    = 32'h0000_0000;
					s_nxt.fwd    = 32'h0000_0000;
					s_nxt.rxb    = 32'h0000_0000;
					s_nxt.pshut  = 2'b00;
				end
			end
			else if (rx_op != `OP_RST)
			begin
				s_nxt.rep_v = 1'b1;
			end
		end

		// transport reset: new cid, drop connection, listener stays
		if (ev_take && ev_id == `EV_TRANSPORT_RESET)
		begin
			s_nxt.lcid = guest_cid[31:0];
			if (s_r.st != ST_IDLE)
			begin
				s_nxt.st      = ST_IDLE;
				s_nxt.p_rst   = 1'b1;
				s_nxt.p_send  = 1'b0;
				s_nxt.p_close = 1'b0;
				s_nxt.p_cred  = 1'b0;
			end
		end

		// apb read data, sampled in the setup cycle
		s_nxt.prdata  = 32'h0000_0000;
		s_nxt.pslverr = 1'b0;
		if (rd)
		begin
			case (paddr)
				`A_CTRL:    s_nxt.prdata = {28'h0, s_r.listen, s_r.p_send,
					s_r.p_close, s_r.p_conn};
				`A_LPORT:   s_nxt.prdata = s_r.lport;
				`A_PCID:    s_nxt.prdata = s_r.pcid;
				`A_PPORT:   s_nxt.prdata = s_r.pport;
				`A_DLEN:    s_nxt.prdata = s_r.dlen;
				`A_BALLOC:  s_nxt.prdata = s_r.balloc;
				`A_CONSUME: s_nxt.prdata = s_r.rxb;
				`A_STATUS:  s_nxt.prdata = {26'h0, s_r.rep_v, s_r.tv,
					s_r.pshut, s_r.st};
				`A_PFREE:   s_nxt.prdata = pfree;
				`A_GCID:    s_nxt.prdata = s_r.lcid;
				`A_TOUT:    s_nxt.prdata = s_r.tout;
				default:    s_nxt.pslverr = 1'b1;
			endcase
		end

		// apb writes take effect at the access edge
		if (wr)
		begin
			case (paddr)
				`A_CTRL:
				begin
					s_nxt.listen = pwdata[`CTRL_LISTEN];
					if (pwdata[`CTRL_CONN] && s_r.st == ST_IDLE)
					begin
						s_nxt.p_conn = 1'b1;
						s_nxt.txc    = 32'h0000_0000;
						s_nxt.fwd    = 32'h0000_0000;
						s_nxt.rxb    = 32'h0000_0000;
						s_nxt.pshut  = 2'b00;
						s_nxt.palloc = 32'h0000_0000;
						s_nxt.pfwd   = 32'h0000_0000;
					end
					if (pwdata[`CTRL_CLOSE] && s_r.st == ST_EST)
					begin
						s_nxt.p_close = 1'b1;
					end
					if (pwdata[`CTRL_SEND] && s_r.st == ST_EST)
					begin
						s_nxt.p_send = 1'b1;
					end
				end
				`A_LPORT:  s_nxt.lport  = pwdata;
				`A_PCID:   s_nxt.pcid   = pwdata;
				`A_PPORT:  s_nxt.pport  = pwdata;
				`A_DLEN:   s_nxt.dlen   = pwdata;
				`A_BALLOC: s_nxt.balloc = pwdata;
				`A_TOUT:   s_nxt.tout   = pwdata;
				`A_CONSUME:
				begin
					s_nxt.fwd = s_r.fwd + pwdata;
					s_nxt.rxb = s_nxt.rxb - pwdata;
					if (s_r.st == ST_EST)
					begin
						s_nxt.p_cred = 1'b1;
					end
				end
				default:
				begin
					s_nxt.pslverr = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_r        <= '0;
			s_r.st     <= ST_IDLE;
			s_r.balloc <= `RST_BALLOC;
			s_r.tout   <= `RST_TOUT;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

endmodule : vs_driver

// ### sim/vs_driver_assertions.sv
// port checker of the stream socket driver engine
`timescale 1ns/100ps
`include "vs_defines.svh"
module vs_driver_chk
(
	input wire logic	pclk,
	input wire logic	presetn,
	input wire logic	tx_valid,
	input wire logic	tx_ready,
	input wire logic [63:0]	tx_src_cid,
	input wire logic [15:0]	tx_type,
	input wire logic [15:0]	tx_op,
	input wire logic [31:0]	tx_flags,
	input wire logic	rx_valid,
	input wire logic	rx_ready,
	input wire logic [15:0]	rx_type,
	input wire logic [15:0]	rx_op,
	input wire logic	ev_valid,
	input wire logic [31:0]	ev_id,
	input wire logic [63:0]	guest_cid
);
	logic [63:0]	cid_r;
	logic		rxt;
	assign rxt = rx_valid && rx_ready;
	// local cid as last loaded by a transport reset event
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			cid_r <= 64'h0;
		else if (ev_valid && ev_id == `EV_TRANSPORT_RESET)
			cid_r <= {32'h0, guest_cid[31:0]};
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_type_stream: assert property (
		tx_valid |-> tx_type == `TYPE_STREAM) else $error("tx type");
	a_src_cid: assert property (
		tx_valid |-> tx_src_cid == cid_r) else $error("tx src cid");
	a_tx_hold: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_op)
		&& $stable(tx_flags)) else $error("tx header moved");
	a_credit_reply: assert property (
		rxt && rx_op == `OP_CRED_REQ |-> ##[1:16]
		tx_valid && tx_op == `OP_CRED_UPD) else $error("no update");
	a_bad_type: assert property (
		rxt && rx_type != `TYPE_STREAM && rx_op != `OP_RST |->
		##[1:16] tx_valid && tx_op == `OP_RST) else $error("no reset");
	a_rst_silent: assert property (
		rxt && rx_type == `TYPE_STREAM && rx_op == `OP_RST
		|=> rx_ready [*3])
		else $error("reset answered");
	a_req_reply: assert property (
		rxt && rx_op == `OP_REQUEST |=> !rx_ready)
		else $error("request unanswered");
	a_shut_both: assert property (
		tx_valid && tx_op == `OP_SHUTDOWN |-> tx_flags == `SHUT_BOTH)
		else $error("shutdown flags");
endmodule : vs_driver_chk

bind vs_driver vs_driver_chk u_chk
(
	.pclk, .presetn, .tx_valid, .tx_ready, .tx_src_cid, .tx_type,
	.tx_op, .tx_flags, .rx_valid, .rx_ready, .rx_type, .rx_op,
	.ev_valid, .ev_id, .guest_cid
);

// ### sim/vs_guest_dev.sv
// behavioural socket device on the far side of the queues
`timescale 1ns/100ps
`include "vs_defines.svh"
module vs_guest_dev
(
	input wire logic	pclk,
	input wire logic	presetn,
	input wire logic	tx_valid,
	output logic		tx_ready,
	output logic		rx_valid,
	input wire logic	rx_ready,
	output logic [351:0]	hdr,
	output logic		ev_valid,
	output logic [31:0]	ev_id,
	output logic [63:0]	guest_cid
);
	int	slow = 0;
	int	wt;
	initial
	begin
		rx_valid = 1'b0;
		hdr = '0;
		ev_valid = 1'b0;
		ev_id = 32'hFFFF_FFFF;
		guest_cid = 64'h3;
	end
	// tx drained at own pace, rx side never blocks it
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			wt <= 0;
		else
			wt <= (tx_valid && !tx_ready) ? wt + 1 : 0;
	assign tx_ready = (wt >= slow);
	// header written into rx, held until taken
	task automatic push(input logic [351:0] h);
		hdr <= h;
		rx_valid <= 1'b1;
		do
			@(posedge pclk);
		while (rx_ready !== 1'b1);
		rx_valid <= 1'b0;
		hdr <= ~h;
		@(posedge pclk);
	endtask : push
	// transport reset, never a reserved cid
	task automatic tr(input logic [63:0] c);
		guest_cid <= (c[31:0] < 3 || &c[31:0]) ? 64'h3 : {32'h0, c[31:0]};
		ev_id <= `EV_TRANSPORT_RESET;
		ev_valid <= 1'b1;
		@(posedge pclk);
		ev_valid <= 1'b0;
		ev_id <= 32'hFFFF_FFFF;
	endtask : tr
endmodule : vs_guest_dev

// ### sim/vs_driver_tb.sv
// self-checking bench of the stream socket driver engine
`timescale 1ns/100ps
`include "vs_defines.svh"
module vs_driver_tb;
	localparam logic [31:0]		L = 32'h0000_0400;
	localparam logic [31:0]		P = 32'h0000_0500;
	localparam logic [63:0]		G1 = 64'h0000_0000_0000_0035;
	localparam logic [63:0]		G2 = 64'h0000_0000_0000_0047;
	localparam logic [143:0]	ALL = '1;
	localparam logic [143:0]	OPD = {16'hFFFF, 64'h0, 32'hFFFF_FFFF, 32'h0};
	localparam logic [127:0]	TXH = {64'h2, L, `RST_BALLOC};
	logic		pclk = 1'b0;
	logic		presetn = 1'b0;
	logic		psel = 1'b0;
	logic		penable = 1'b0;
	logic		pwrite = 1'b0;
	logic [7:0]	paddr = 8'h00;
	logic [31:0]	pwdata = 32'h0;
	logic		pready, pslverr, tx_valid, tx_ready, rx_valid, rx_ready;
	logic		ev_valid, ev_ready;
	logic [15:0]	tx_type, tx_op, rx_type, rx_op;
	logic [31:0]	prdata, tx_src_port, tx_dst_port, tx_len, tx_flags;
	logic [31:0]	tx_buf_alloc, tx_fwd_cnt, rx_src_port, rx_dst_port;
	logic [31:0]	rx_len, rx_flags, rx_buf_alloc, rx_fwd_cnt, ev_id;
	logic [63:0]	tx_src_cid, tx_dst_cid, rx_src_cid, rx_dst_cid;
	logic [63:0]	guest_cid, gc;
	logic [351:0]	hdr;
	logic [143:0]	q[$];
	logic [32:0]	rv;
	int		fails = 0;
	int		n_tests = 0;
	int		cyc = 0;
	assign {rx_src_cid, rx_dst_cid, rx_src_port, rx_dst_port, rx_len,
		rx_type, rx_op, rx_flags, rx_buf_alloc, rx_fwd_cnt} = hdr;
	vs_driver u_dut
	(
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .guest_cid, .tx_valid, .tx_ready,
		.tx_src_cid, .tx_dst_cid, .tx_src_port, .tx_dst_port, .tx_len,
		.tx_type, .tx_op, .tx_flags, .tx_buf_alloc, .tx_fwd_cnt,
		.rx_valid, .rx_ready, .rx_src_cid, .rx_dst_cid, .rx_src_port,
		.rx_dst_port, .rx_len, .rx_type, .rx_op, .rx_flags,
		.rx_buf_alloc, .rx_fwd_cnt, .ev_valid, .ev_ready, .ev_id
	);
	vs_guest_dev u_dev
	(
		.pclk, .presetn, .tx_valid, .tx_ready, .rx_valid, .rx_ready,
		.hdr, .ev_valid, .ev_id, .guest_cid
	);
	always #2.5 pclk = ~pclk;
	// log of accepted tx headers, and the hang limit
	always @(posedge pclk)
	begin
		if (tx_valid && tx_ready)
		begin
			q.push_back({tx_op, tx_len, tx_flags, tx_dst_port, tx_fwd_cnt});
			chk({tx_dst_cid, tx_src_port, tx_buf_alloc}, TXH);
		end
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			finish_test();
		end
	end
	task automatic chk(input logic [143:0] a, input logic [143:0] e);
		n_tests++;
		if (a !== e)
		begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, a, e);
		end
	endtask : chk
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rv = {pslverr, prdata};
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer
	task rd(input logic [7:0] a, input logic [32:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rv, e);
	endtask : rd
	task st(input logic [1:0] e);
		xfer(1'b0, `A_STATUS, 32'h0);
		chk(rv[1:0], e);
	endtask : st
	task pk(input logic [15:0] ty, op, input logic [31:0] sp, ln, fl, fw);
		u_dev.push({64'h2, gc, sp, L, ln, ty, op, fl, 32'h100, fw});
	endtask : pk
	task got(input logic [143:0] e, m);
		while (q.size() == 0)
			@(posedge pclk);
		chk(q.pop_front() & m, e & m);
	endtask : got
	task finish_test();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test
	initial
	begin
		gc = G1;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(`A_STATUS, 33'h0);
		rd(`A_BALLOC, {1'b0, `RST_BALLOC});
		rd(`A_TOUT, {1'b0, `RST_TOUT});
		rd(8'h40, 33'h1_0000_0000);
		u_dev.tr(G1);
		rd(`A_GCID, {1'b0, G1[31:0]});
		wr_all();
		$display("test registers done");
		pk(`TYPE_STREAM, `OP_REQUEST, P, 32'h0, 32'h0, 32'hFFFF_FF80);
		got({`OP_RESPONSE, 64'h0, P, 32'h0}, ALL);
		rd(`A_STATUS, 33'h2);
		rd(`A_PFREE, 33'h80);
		rd(`A_PCID, 33'h2);
		pk(`TYPE_STREAM, `OP_REQUEST, P + 1, 32'h0, 32'h0, 32'h0);
		got({`OP_RST, 64'h0, P + 32'h1, 32'h0}, OPD);
		$display("test connect done");
		u_dev.slow = 3;
		xfer(1'b1, `A_DLEN, 32'h80);
		xfer(1'b1, `A_CTRL, 32'hC);
		got({`OP_RW, 32'h80, 32'h0, P, 32'h0}, ALL);
		rd(`A_PFREE, 33'h0);
		xfer(1'b1, `A_CTRL, 32'hC);
		repeat (10) @(posedge pclk);
		chk(q.size(), 0);
		pk(`TYPE_STREAM, `OP_CRED_UPD, P, 32'h0, 32'h0, 32'h0);
		got({`OP_RW, 32'h80, 32'h0, P, 32'h0}, ALL);
		u_dev.slow = 0;
		pk(`TYPE_STREAM, `OP_CRED_REQ, P, 32'h0, 32'h0, 32'h0);
		got({`OP_CRED_UPD, 64'h0, P, 32'h0}, ALL);
		pk(`TYPE_STREAM, `OP_RW, P, 32'h20, 32'h0, 32'h0);
		rd(`A_CONSUME, 33'h20);
		xfer(1'b1, `A_CONSUME, 32'h20);
		got({`OP_CRED_UPD, 64'h0, P, 32'h20}, ALL);
		$display("test credit done");
		pk(`TYPE_STREAM, `OP_SHUTDOWN, P, 32'h0, 32'h1, 32'h0);
		rd(`A_STATUS, 33'h6);
		pk(`TYPE_STREAM, `OP_SHUTDOWN, P, 32'h0, 32'h0, 32'h0);
		rd(`A_STATUS, 33'h6);
		xfer(1'b1, `A_CTRL, 32'hA);
		got({`OP_SHUTDOWN, 32'h0, `SHUT_BOTH, P, 32'h20}, ALL);
		rd(`A_STATUS, 33'h7);
		got({`OP_RST, 64'h0, P, 32'h0}, OPD);
		st(2'h0);
		$display("test close done");
		xfer(1'b1, `A_CTRL, 32'h9);
		got({`OP_REQUEST, 64'h0, P, 32'h0}, OPD);
		st(2'h1);
		pk(`TYPE_STREAM, `OP_RST, P, 32'h0, 32'h0, 32'h0);
		st(2'h0);
		pk(`TYPE_STREAM, `OP_REQUEST, P, 32'h0, 32'h0, 32'h0);
		got({`OP_RESPONSE, 64'h0, P, 32'h0}, OPD);
		u_dev.tr(G2);
		got({`OP_RST, 64'h0, P, 32'h0}, OPD);
		st(2'h0);
		rd(`A_GCID, {1'b0, G2[31:0]});
		xfer(1'b0, `A_CTRL, 32'h0);
		chk(rv[3], 1'b1);
		gc = G2;
		pk(`TYPE_STREAM, `OP_REQUEST, P, 32'h0, 32'h0, 32'h0);
		got({`OP_RESPONSE, 64'h0, P, 32'h0}, OPD);
		pk(16'h0002, `OP_RW, P, 32'h0, 32'h0, 32'h0);
		got({`OP_RST, 64'h0, P, 32'h0}, OPD);
		$display("test reset paths done");
		finish_test();
	end
	task wr_all();
		xfer(1'b1, `A_TOUT, 32'h10);
		xfer(1'b1, `A_LPORT, L);
		xfer(1'b1, `A_PCID, 32'h9);
		xfer(1'b1, `A_PPORT, P);
		xfer(1'b1, `A_CTRL, 32'h8);
	endtask : wr_all
endmodule : vs_driver_tb
